// >>> bench/sbp_codec.sv
`timescale 1ns/1ns
module sbp_codec #(
  parameter int WORD_W = 8
) (
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic serial_in,
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  input wire logic serial_out
);
  initial begin
    rx_bit_clock = 1'b1;
    rx_frame_sync = 1'b0;
    serial_in = 1'b0;
    tx_bit_clock = 1'b0;
    tx_frame_sync = 1'b0;
  end
  // sync period then n bits msb first; clock idles outside frames
  task automatic rx_frame(input logic [15:0] w, input int n);
    #10;
    for (int p = 0; p <= n; p++) begin
      rx_frame_sync = (p == 0);
      if (p > 0) serial_in = w[WORD_W-p];
      #200 rx_bit_clock = 1'b0;
      #200 rx_bit_clock = 1'b1;
    end
    rx_frame_sync = 1'b0;
    serial_in = ~serial_in;
  endtask
  // n periods from the sync, one bit captured per period
  task automatic tx_frame(input int n, output logic [15:0] w);
    #10;
    w = 16'h0000;
    for (int p = 0; p < n; p++) begin
      tx_frame_sync = (p == 0);
      #100 tx_bit_clock = 1'b1;
      #200 tx_bit_clock = 1'b0;
      #100 w = {w[14:0], serial_out};
    end
    tx_frame_sync = 1'b0;
  endtask
endmodule

// >>> bench/sbp_top_props.sv
`timescale 1ns/1ns
`include "sbp_map.svh"
module sbp_top_props #(
  parameter int WORD_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`SBP_ADDR_W-1:0] reg_addr,
  input wire logic [`SBP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SBP_DATA_W-1:0] reg_rdata,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic serial_in,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic serial_out,
  input wire logic rx_irq,
  input wire logic tx_irq,
  input wire logic rx_dma_event,
  input wire logic tx_dma_event
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_set;
    reg_wr && reg_addr == 4'h0 && reg_wdata[6] && reg_wdata[0];
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_zero;
    reg_rd && !(reg_addr inside {4'h0, 4'h4, 4'h8}) |=> reg_rdata == 16'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
  property p_rx_dma;
    rx_dma_event |=> !rx_dma_event;
  endproperty
  a_rx_dma: assert property (p_rx_dma) else $error("dma pulse long");
  property p_tx_dma;
    tx_dma_event |=> !tx_dma_event;
  endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("tx dma long");
  property p_ctl_rw;
    reg_wr && reg_addr == 4'h0 ##2 s_rd(4'h0) |=> {reg_rdata[5:4],
      reg_rdata[1:0]} == $past({reg_wdata[5:4], reg_wdata[1:0]}, 3);
  endproperty
  a_ctl_rw: assert property (p_ctl_rw) else $error("control readback");
  property p_err_set;
    s_set ##2 s_rd(4'h0) |=> reg_rdata[6];
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not set");
  property p_ovr_clr;
    s_rd(4'h8) ##2 s_rd(4'h0) |=> !reg_rdata[7];
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept");
  property p_rx_irq;
    s_rd(4'h0) ##1 (reg_rdata[5:4] == 2'h3 && reg_rdata[6]) |=> rx_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq low");
  property p_tx_irq;
    s_rd(4'h4) ##1 (reg_rdata[5:4] == 2'h3 && reg_rdata[6]) |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq low");
endmodule
bind sbp_top sbp_top_props #(.WORD_W(WORD_W)) u_sbp_top_props (
  .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
  .serial_in(serial_in), .tx_bit_clock(tx_bit_clock),
  .tx_frame_sync(tx_frame_sync), .serial_out(serial_out), .rx_irq(rx_irq),
  .tx_irq(tx_irq), .rx_dma_event(rx_dma_event), .tx_dma_event(tx_dma_event)
);

// >>> bench/sbp_top_tb.sv
`timescale 1ns/1ns
module sbp_top_tb;
  localparam int W = 8;
  localparam logic [15:0] M = 16'hFFFF;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] reg_rdata;
  logic rx_bit_clock, rx_frame_sync, serial_in, serial_out;
  logic tx_bit_clock, tx_frame_sync, rx_irq, tx_irq;
  logic rx_dma_event, tx_dma_event;
  logic [15:0] dw[4];
  logic [15:0] w;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'hc490;
  sbp_top #(.WORD_W(W)) u_sbp_top (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_bit_clock(rx_bit_clock),
    .rx_frame_sync(rx_frame_sync), .serial_in(serial_in),
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .serial_out(serial_out), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .rx_dma_event(rx_dma_event), .tx_dma_event(tx_dma_event)
  );
  sbp_codec #(.WORD_W(W)) u_sbp_codec (
    .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .serial_in(serial_in), .tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .serial_out(serial_out)
  );
  always #25 mclk = ~mclk;
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    checked++;
    if (got !== e) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // expected value noted here, compared by the watcher below
  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask
  task automatic rf(input logic [15:0] x, input int n);
    u_sbp_codec.rx_frame(x, n);
  endtask
  task automatic tf(input int n);
    u_sbp_codec.tx_frame(n, w);
  endtask
  task automatic tend(input string s);
    settle;
    $display("test %0s done", s);
  endtask
  always @(posedge mclk) begin
    if (rd_d) begin
      chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      stop_test;
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      dw[i] = {8'h00, 8'($random(seed))};
    end
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h0, 16'h0000, M);
    rd(4'h4, 16'h0100, M);
    rd(4'hC, 16'h0000, M);
    rd(4'h2, 16'h0000, M);
    tend("reset");
    wr(4'h0, 16'h0005);
    rd(4'h0, 16'h0005, M);
    rf(dw[0], W);
    settle;
    rd(4'h0, 16'h0105, M);
    rf(dw[1], W);
    settle;
    rd(4'h0, 16'h0105, M);
    rf(dw[2], W);
    settle;
    rd(4'h0, 16'h0185, M);
    rf(dw[3], W);
    rd(4'h8, dw[0], M);
    rd(4'h0, 16'h0000, 16'h0080);
    rd(4'h8, dw[1], M);
    tend("overrun");
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0035);
    rf(dw[0], W);
    rf(dw[1], W);
    rf(dw[2], 4);
    rf(dw[3], W);
    settle;
    rd(4'h0, 16'h0175, M);
    chk({15'h0000, rx_irq}, 16'h0001);
    rd(4'h8, dw[0], M);
    settle;
    rd(4'h8, dw[3], M);
    wr(4'h0, 16'h0035);
    rd(4'h0, 16'h0035, M);
    wr(4'h0, 16'h0075);
    rd(4'h0, 16'h0075, M);
    tend("rx sync error");
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0007);
    rf(dw[0], 4);
    rf(dw[1], W);
    settle;
    w = {8'h00, dw[0][7:4], ~dw[0][4], dw[1][7:5]};
    rd(4'h0, 16'h0000, 16'h0040);
    rd(4'h8, w, M);
    tend("rx ignore");
    wr(4'h4, 16'h0035);
    tf(9);
    chk(w & 16'h00FF, 16'h0000);
    rd(4'h4, 16'h0000, 16'h0080);
    wr(4'hC, dw[0]);
    wr(4'hC, dw[1]);
    tf(9);
    chk(w & 16'h00FF, dw[1]);
    tf(9);
    chk(w & 16'h00FF, dw[1]);
    rd(4'h4, 16'h0100, 16'h0100);
    wr(4'hC, dw[2]);
    tf(5);
    tf(9);
    chk(w & 16'h00FF, dw[2]);
    rd(4'h4, 16'h0040, 16'h0040);
    settle;
    chk({15'h0000, tx_irq}, 16'h0001);
    wr(4'h4, 16'h0037);
    tf(5);
    tf(9);
    settle;
    rd(4'h4, 16'h0000, 16'h0040);
    tend("transmit");
    stop_test;
  end
endmodule

// >>> logic/sbp_map.svh
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
`define SBP_ADDR_W 4
`define SBP_DATA_W 16
`define SBP_OFS_CTRL_ONE 4'h0
`define SBP_OFS_CTRL_TWO 4'h4
`define SBP_OFS_RX_DATA 4'h8
`define SBP_OFS_TX_DATA 4'hC
`define SBP_BIT_RESET_N 0
`define SBP_BIT_IGNORE 1
`define SBP_BIT_DELAY 2
`define SBP_BIT_IRQ_SEL 4
`define SBP_BIT_SYNC_ERR 6
`define SBP_CTRL_RST 6'h00
`define SBP_DELAY_MAX 2'h2
`define SBP_IRQ_READY 2'h0
`define SBP_IRQ_SYNC_ERR 2'h3
`endif

// >>> logic/sbp_pkg.sv
package sbp_pkg;
  typedef logic [1:0] sbp_delay_t;
  typedef logic [4:0] sbp_count_t;
  typedef logic [15:0] sbp_word_t;
  typedef enum logic [1:0] {
    SBP_ST_IDLE = 2'b01,
    SBP_ST_RUN = 2'b10
  } sbp_state_t;
endpackage

// >>> logic/sbp_sync.sv
`timescale 1ns/1ns
module sbp_sync #(
  parameter int N = 3
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;
  if (N < 1) begin : g_chk
    $error("sync width must be at least one");
  end
  // two stages before use, third stage only for edge finding
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule

// >>> logic/sbp_top.sv
// Operation
// - early receive sync without ignore drops partial word, flags error, restarts.
// - early receive sync with ignore set is ignored, shifting continues.
// - early transmit sync without ignore aborts, flags error, resends word.
// - early transmit sync with ignore set is ignored, no flag.
// - sync is early when more bits than the data delay remain.
// - receive sync restart drops any word waiting in the buffer.
// - transmit restart sends new data if written since last copy.
// - overrun when data unread, buffer full and shift register full.
// - shift to buffer only after buffer to data; copy only when not ready.
// - during overrun the shift register keeps being overwritten.
// - overrun cannot occur before three words after receiver reset.
// - overrun clears on data read, receiver reset or device reset.
// - after overrun clears, reception waits for a new sync.
// - second transmit write before copy replaces the first.
// - sync without new data marks empty and resends the old word.
// - receive sync error sticks until receiver reset or zero write.
// - writing one to a sync error flag sets it.
// - receive interrupt selection 11b routes receive sync error.
// - first sync after reset, after overrun or in a gap is normal.
// - the same sync handling applies to any sync source.
// - transmit sync error sticks until transmitter reset or zero write.
// - transmit interrupt selection 11b routes transmit sync error.
`timescale 1ns/1ns
`include "sbp_map.svh"
module sbp_top import sbp_pkg::*; #(
  parameter int WORD_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`SBP_ADDR_W-1:0] reg_addr,
  input wire logic [`SBP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SBP_DATA_W-1:0] reg_rdata,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic serial_in,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  output logic serial_out,
  output logic rx_irq,
  output logic tx_irq,
  output logic rx_dma_event,
  output logic tx_dma_event
);
  localparam sbp_count_t WLEN = sbp_count_t'(WORD_W);
  localparam sbp_word_t WMASK = sbp_word_t'((17'h00001 << WORD_W) - 17'h00001);
  logic [5:0] ctrl_one_r, ctrl_two_r;
  logic wr_one, wr_two, wr_txd, rd_rxd;
  logic [2:0] rx_lvl, rx_fall;
  logic [1:0] tx_lvl, tx_rise;
  sbp_delay_t rx_dly, tx_dly;
  sbp_state_t rx_state_r;
  sbp_count_t rx_rem_r, rx_rem_nxt, rx_q_rem_r, q_now, dly;
  sbp_word_t rx_shift_r, rx_shift_nxt, word, rx_rsr_r, rx_rbr_r, rx_drr_r;
  logic rx_rst, rx_ignore, rx_edge, fs_evt, busy, unexp, q_set, done;
  logic sync_hit, rx_halt, rx_q_r, rx_fs_prev_r, copy_bd;
  logic rx_rsr_full_r, rx_rbr_full_r, rx_ready_r, rx_ovr_r, rx_err_r;
  logic ovr_cond, ovr_prev_r;
  logic [`SBP_DATA_W-1:0] rdata_r;
  logic rx_irq_r, tx_irq_r, rx_dma_r;
  sbp_tx_if txi();
  if (WORD_W < 2 || WORD_W > 16) begin : g_chk
    $error("word width out of range");
  end
  // register port decode
  assign wr_one = reg_wr && (reg_addr == `SBP_OFS_CTRL_ONE);
  assign wr_two = reg_wr && (reg_addr == `SBP_OFS_CTRL_TWO);
  assign wr_txd = reg_wr && (reg_addr == `SBP_OFS_TX_DATA);
  assign rd_rxd = reg_rd && (reg_addr == `SBP_OFS_RX_DATA);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_one_r <= `SBP_CTRL_RST;
      ctrl_two_r <= `SBP_CTRL_RST;
    end else begin
      if (wr_one) begin
        ctrl_one_r <= reg_wdata[5:0];
      end
      if (wr_two) begin
        ctrl_two_r <= reg_wdata[5:0];
      end
    end
  end
  // delay code 3 behaves as the largest legal delay
  assign rx_dly = (ctrl_one_r[`SBP_BIT_DELAY +: 2] > `SBP_DELAY_MAX) ?
    `SBP_DELAY_MAX : ctrl_one_r[`SBP_BIT_DELAY +: 2];
  assign tx_dly = (ctrl_two_r[`SBP_BIT_DELAY +: 2] > `SBP_DELAY_MAX) ?
    `SBP_DELAY_MAX : ctrl_two_r[`SBP_BIT_DELAY +: 2];
  assign rx_rst = ~ctrl_one_r[`SBP_BIT_RESET_N];
  assign rx_ignore = ctrl_one_r[`SBP_BIT_IGNORE];
  // link inputs
  sbp_sync #(.N(3)) u_rx_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in({serial_in, rx_frame_sync, rx_bit_clock}),
    .level(rx_lvl),
    .rise(),
    .fall(rx_fall)
  );
  sbp_sync #(.N(2)) u_tx_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in({tx_frame_sync, tx_bit_clock}),
    .level(tx_lvl),
    .rise(tx_rise),
    .fall()
  );
  // transmitter
  assign txi.reset_n = ctrl_two_r[`SBP_BIT_RESET_N];
  assign txi.ignore = ctrl_two_r[`SBP_BIT_IGNORE];
  assign txi.delay = tx_dly;
  assign txi.data_wr = wr_txd;
  assign txi.wdata = reg_wdata & WMASK;
  assign txi.err_wr = wr_two;
  assign txi.err_wdata = reg_wdata[`SBP_BIT_SYNC_ERR];
  assign txi.bit_edge = tx_rise[0];
  assign txi.fs_level = tx_lvl[1];
  sbp_tx #(.WORD_W(WORD_W)) u_tx (
    .mclk(mclk),
    .rst_b(rst_b),
    .io(txi)
  );
  // receiver, sampled on falling bit clock edges
  assign rx_edge = rx_fall[0];
  assign fs_evt = rx_edge & rx_lvl[1] & ~rx_fs_prev_r;
  assign dly = sbp_count_t'(rx_dly);
  assign unexp = fs_evt && busy && (rx_rem_r > dly);
  assign q_now = WLEN + dly - rx_rem_r;
  assign rx_halt = rx_rst || (rd_rxd && rx_ovr_r);
  assign word = rx_shift_nxt & WMASK;
  always_comb begin
    case (rx_state_r)
      SBP_ST_RUN: busy = 1'b1;
      SBP_ST_IDLE: busy = 1'b0;
      default: busy = 1'b0;
    endcase
  end
  always_comb begin
    rx_rem_nxt = rx_rem_r;
    rx_shift_nxt = rx_shift_r;
    sync_hit = 1'b0;
    q_set = 1'b0;
    done = 1'b0;
    if (rx_edge && !rx_halt) begin
      if (fs_evt && !busy) begin
        rx_rem_nxt = WLEN + dly;
      end else if (unexp && !rx_ignore) begin
        rx_rem_nxt = WLEN + dly;
        rx_shift_nxt = 16'h0000;
        sync_hit = 1'b1;
      end else if (fs_evt && !unexp) begin
        q_set = 1'b1;
      end
      if (rx_rem_nxt != 5'h00) begin
        if (rx_rem_nxt <= WLEN) begin
          rx_shift_nxt = {rx_shift_nxt[14:0], rx_lvl[2]};
        end
        rx_rem_nxt = rx_rem_nxt - 5'h01;
        if (rx_rem_nxt == 5'h00) begin
          done = 1'b1;
          rx_rem_nxt = q_set ? q_now : (rx_q_r ? rx_q_rem_r : 5'h00);
        end
      end
    end
  end
  // an ignored early pulse leaves the word running
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_r <= SBP_ST_IDLE;
      rx_rem_r <= 5'h00;
      rx_shift_r <= 16'h0000;
      rx_q_r <= 1'b0;
      rx_q_rem_r <= 5'h00;
      rx_fs_prev_r <= 1'b0;
    end else if (rx_halt) begin
      rx_state_r <= SBP_ST_IDLE;
      rx_rem_r <= 5'h00;
      rx_q_r <= 1'b0;
    end else if (rx_edge) begin
      rx_state_r <= (rx_rem_nxt != 5'h00) ? SBP_ST_RUN : SBP_ST_IDLE;
      rx_rem_r <= rx_rem_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_fs_prev_r <= rx_lvl[1];
      if (done || sync_hit) begin
        rx_q_r <= 1'b0;
      end else if (q_set) begin
        rx_q_r <= 1'b1;
        rx_q_rem_r <= q_now;
      end
    end
  end
  // shift, buffer and data register chain
  assign copy_bd = rx_rbr_full_r && !rx_ready_r && !sync_hit;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_rbr_full_r <= 1'b0;
      rx_rsr_full_r <= 1'b0;
      rx_rbr_r <= 16'h0000;
      rx_rsr_r <= 16'h0000;
    end else if (rx_rst || sync_hit) begin
      rx_rbr_full_r <= 1'b0;
      rx_rsr_full_r <= 1'b0;
    end else begin
      if (copy_bd) begin
        rx_rbr_full_r <= 1'b0;
      end
      if (!rx_rbr_full_r && rx_rsr_full_r) begin
        rx_rbr_r <= rx_rsr_r;
        rx_rbr_full_r <= 1'b1;
        rx_rsr_full_r <= 1'b0;
      end else if (!rx_rbr_full_r && done) begin
        rx_rbr_r <= word;
        rx_rbr_full_r <= 1'b1;
      end
      if (done && (rx_rbr_full_r || rx_rsr_full_r)) begin
        rx_rsr_r <= word;
        rx_rsr_full_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ready_r <= 1'b0;
      rx_drr_r <= 16'h0000;
      rx_dma_r <= 1'b0;
    end else begin
      rx_dma_r <= copy_bd;
      if (rx_rst) begin
        rx_ready_r <= 1'b0;
      end else if (copy_bd) begin
        rx_drr_r <= rx_rbr_r;
        rx_ready_r <= 1'b1;
      end else if (rd_rxd) begin
        rx_ready_r <= 1'b0;
      end
    end
  end
  // overrun needs all three stages full, so three words at least
  assign ovr_cond = rx_ready_r && rx_rbr_full_r && rx_rsr_full_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_prev_r <= 1'b0;
      rx_ovr_r <= 1'b0;
    end else if (rx_rst) begin
      ovr_prev_r <= 1'b0;
      rx_ovr_r <= 1'b0;
    end else begin
      ovr_prev_r <= ovr_cond;
      if (ovr_cond && !ovr_prev_r) begin
        rx_ovr_r <= 1'b1;
      end else if (rd_rxd) begin
        rx_ovr_r <= 1'b0;
      end
    end
  end
  // sticky sync error, set wins over a written zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_err_r <= 1'b0;
    end else if (rx_rst) begin
      rx_err_r <= 1'b0;
    end else if (sync_hit || (wr_one && reg_wdata[`SBP_BIT_SYNC_ERR])) begin
      rx_err_r <= 1'b1;
    end else if (wr_one) begin
      rx_err_r <= 1'b0;
    end
  end
  // interrupt routing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_irq_r <= 1'b0;
      tx_irq_r <= 1'b0;
    end else begin
      case (ctrl_one_r[`SBP_BIT_IRQ_SEL +: 2])
        `SBP_IRQ_READY: rx_irq_r <= rx_ready_r;
        `SBP_IRQ_SYNC_ERR: rx_irq_r <= rx_err_r;
        default: rx_irq_r <= 1'b0;
      endcase
      case (ctrl_two_r[`SBP_BIT_IRQ_SEL +: 2])
        `SBP_IRQ_READY: tx_irq_r <= txi.ready;
        `SBP_IRQ_SYNC_ERR: tx_irq_r <= txi.sync_error;
        default: tx_irq_r <= 1'b0;
      endcase
    end
  end
  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SBP_OFS_CTRL_ONE: rdata_r <= {7'h00, rx_ready_r, rx_ovr_r,
          rx_err_r, ctrl_one_r};
        `SBP_OFS_CTRL_TWO: rdata_r <= {7'h00, txi.ready, txi.empty_n,
          txi.sync_error, ctrl_two_r};
        `SBP_OFS_RX_DATA: rdata_r <= rx_drr_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_r;
  assign rx_irq = rx_irq_r;
  assign tx_irq = tx_irq_r;
  assign rx_dma_event = rx_dma_r;
  assign tx_dma_event = txi.dma_event;
  assign serial_out = txi.serial_out;
endmodule

// >>> logic/sbp_tx.sv
`timescale 1ns/1ns
module sbp_tx import sbp_pkg::*; #(
  parameter int WORD_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  sbp_tx_if.tx io
);
  localparam sbp_count_t WLEN = sbp_count_t'(WORD_W);
  sbp_word_t data_r, shift_r, word_cur;
  sbp_count_t rem_r, rem_nxt, q_rem_r, q_now, dly;
  logic pend_r, q_r, fs_prev_r, err_r, empty_n_r, ready_r, dma_r, out_r;
  logic rst, fs_evt, busy, unexp, start_a, start_b, q_set, done;
  logic err_hit, copy, bit_on, bit_val;
  if (WORD_W < 2 || WORD_W > 16) begin : g_chk
    $error("word width out of range");
  end
  assign rst = ~io.reset_n;
  assign dly = sbp_count_t'(io.delay);
  assign fs_evt = io.bit_edge & io.fs_level & ~fs_prev_r;
  assign busy = rem_r != 5'h00;
  assign unexp = fs_evt && busy && (rem_r > dly);
  assign q_now = WLEN + dly - rem_r;
  assign copy = (start_a || start_b) && pend_r;
  assign word_cur = (start_a && pend_r) ? data_r : shift_r;
  always_comb begin
    rem_nxt = rem_r;
    start_a = 1'b0;
    start_b = 1'b0;
    q_set = 1'b0;
    done = 1'b0;
    err_hit = 1'b0;
    bit_on = 1'b0;
    bit_val = 1'b0;
    if (io.bit_edge && !rst) begin
      if (fs_evt && !busy) begin
        rem_nxt = WLEN + dly;
        start_a = 1'b1;
      end else if (unexp && !io.ignore) begin
        rem_nxt = WLEN + dly;
        start_a = 1'b1;
        err_hit = 1'b1;
      end else if (fs_evt && !unexp) begin
        q_set = 1'b1;
      end
      if (rem_nxt != 5'h00) begin
        if (rem_nxt <= WLEN) begin
          bit_on = 1'b1;
          bit_val = word_cur[4'(rem_nxt - 5'h01)];
        end
        rem_nxt = rem_nxt - 5'h01;
        if (rem_nxt == 5'h00) begin
          done = 1'b1;
          start_b = q_set || q_r;
          rem_nxt = q_set ? q_now : (q_r ? q_rem_r : 5'h00);
        end
      end
    end
  end
  // word timing; an ignored early pulse changes nothing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rem_r <= 5'h00;
      q_r <= 1'b0;
      q_rem_r <= 5'h00;
      fs_prev_r <= 1'b0;
      out_r <= 1'b0;
    end else if (rst) begin
      rem_r <= 5'h00;
      q_r <= 1'b0;
      out_r <= 1'b0;
    end else if (io.bit_edge) begin
      rem_r <= rem_nxt;
      fs_prev_r <= io.fs_level;
      out_r <= bit_on & bit_val;
      if (done || err_hit) begin
        q_r <= 1'b0;
      end else if (q_set) begin
        q_r <= 1'b1;
        q_rem_r <= q_now;
      end
    end
  end
  // data and shift registers, last write replaces the earlier one
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_r <= 16'h0000;
      shift_r <= 16'h0000;
      pend_r <= 1'b0;
    end else begin
      if (io.data_wr) begin
        data_r <= io.wdata;
      end
      if (rst) begin
        shift_r <= 16'h0000;
      end else if (copy) begin
        shift_r <= data_r;
      end
      if (io.data_wr) begin
        pend_r <= 1'b1;
      end else if (rst || copy) begin
        pend_r <= 1'b0;
      end
    end
  end
  // empty and ready status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      empty_n_r <= 1'b0;
      ready_r <= 1'b1;
      dma_r <= 1'b0;
    end else begin
      dma_r <= copy;
      if (rst) begin
        empty_n_r <= 1'b0;
        ready_r <= 1'b1;
      end else begin
        if (copy) begin
          empty_n_r <= 1'b1;
        end else if ((start_a || start_b || done) && !pend_r) begin
          empty_n_r <= 1'b0;
        end
        if (copy) begin
          ready_r <= 1'b1;
        end else if (io.data_wr) begin
          ready_r <= 1'b0;
        end
      end
    end
  end
  // sticky sync error, set wins over a written zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      err_r <= 1'b0;
    end else if (rst) begin
      err_r <= 1'b0;
    end else if (err_hit || (io.err_wr && io.err_wdata)) begin
      err_r <= 1'b1;
    end else if (io.err_wr) begin
      err_r <= 1'b0;
    end
  end
  assign io.sync_error = err_r;
  assign io.empty_n = empty_n_r;
  assign io.ready = ready_r;
  assign io.dma_event = dma_r;
  assign io.serial_out = out_r;
endmodule

// >>> logic/sbp_tx_if.sv
`timescale 1ns/1ns
interface sbp_tx_if;
  import sbp_pkg::*;
  logic reset_n;
  logic ignore;
  sbp_delay_t delay;
  logic data_wr;
  sbp_word_t wdata;
  logic err_wr;
  logic err_wdata;
  logic bit_edge;
  logic fs_level;
  logic sync_error;
  logic empty_n;
  logic ready;
  logic dma_event;
  logic serial_out;
  modport ctl (
    output reset_n, ignore, delay, data_wr, wdata, err_wr, err_wdata,
    output bit_edge, fs_level,
    input sync_error, empty_n, ready, dma_event, serial_out
  );
  modport tx (
    input reset_n, ignore, delay, data_wr, wdata, err_wr, err_wdata,
    input bit_edge, fs_level,
    output sync_error, empty_n, ready, dma_event, serial_out
  );
endinterface
